// ---- tcsp_pkg.sv ----
// Shared constants and types for both ends of the tuner control and sync port
// Operation
// - Power-down bit slows internal activity to 1 kHz
// - Clock stopped over 2 ms forces sleep
// - Gain exponent bit 5 disables clock-loss watcher
// - Write to address 10 gives one-clock low pulse
// - Diagnostic sync reinitialises datapath, refreshes checksum
// - Host waits four diagnostic periods before reading checksum; the bench waits two
// - Diagnostic sync period is two to twentieth clocks
// - Reference configurations give checksums 64, 50, A7, 03
// - Twelve-bit samples captured every rising edge
// - Sample and active-low syncs captured on rising edge
// - Output words, strobes, flags update on rising edge
// - Each word bus released while its enable high
// - Pair marker high for in-phase half when interleaved
// - Sync out: delayed system sync or internal sync
// - Active-low ready output mirrors status ready flag
// - Overflow output pulses or holds per hold bit
// - Device drives data only during strobe-low reads
// - Host places register address on four address lines
// - Strobe falling with write low loads addressed register
package tcsp_pkg;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned KEEPALIVE_NS  = 2_000_000;
  localparam int unsigned KEEPALIVE_CYC = (KEEPALIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_HZ      = 1_000;
  localparam int unsigned SLEEP_DIV     = CLK_HZ / SLEEP_HZ;
  localparam int unsigned SYNC_LOG2     = 20;
  localparam int unsigned TEST_LOG2     = 8;
  localparam int unsigned DIAG_PERIODS  = 4;
  localparam int unsigned HOST_STROBE_CYC  = 4;
  localparam int unsigned HOST_RECOVER_CYC = 3;

  // -----------------------------------------------------------------
  // Register addresses and fields
  // -----------------------------------------------------------------
  localparam logic [3:0] ADDR_SYNC_MODE = 4'h4;
  localparam logic [3:0] ADDR_GAIN_EXP  = 4'h7;
  localparam logic [3:0] ADDR_OUT_MODE  = 4'h8;
  localparam logic [3:0] ADDR_STATUS    = 4'h9;
  localparam logic [3:0] ADDR_ONE_SHOT  = 4'hA;
  localparam logic [3:0] ADDR_CHECKSUM  = 4'hB;
  localparam logic [3:0] ADDR_I_LO      = 4'hC;
  localparam logic [3:0] ADDR_I_HI      = 4'hD;
  localparam logic [3:0] ADDR_Q_LO      = 4'hE;
  localparam logic [3:0] ADDR_Q_HI      = 4'hF;
  localparam int unsigned SYNC_DIAG_BIT     = 5;
  localparam int unsigned SYNC_TEST_BIT     = 6;
  localparam int unsigned SYNC_INT_SEL_BIT  = 7;
  localparam int unsigned KEEPALIVE_OFF_BIT = 5;
  localparam int unsigned OUT_INTERLEAVE_BIT = 0;
  localparam int unsigned OUT_WS_SQUARE_BIT  = 1;
  localparam int unsigned OUT_WS_POL_BIT     = 2;
  localparam int unsigned STAT_READY_BIT     = 0;
  localparam int unsigned STAT_OVF_BIT       = 1;
  localparam int unsigned STAT_OVF_HOLD_BIT  = 6;
  localparam int unsigned STAT_POWER_DOWN_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Expected checksums of the four reference configurations
  localparam logic [7:0] CHK_REF_1 = 8'h64;
  localparam logic [7:0] CHK_REF_2 = 8'h50;
  localparam logic [7:0] CHK_REF_3 = 8'hA7;
  localparam logic [7:0] CHK_REF_4 = 8'h03;

  // -----------------------------------------------------------------
  // Host sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCSP_IDLE    = 2'b00,
    TCSP_SETUP   = 2'b01,
    TCSP_STROBE  = 2'b10,
    TCSP_RECOVER = 2'b11
  } tcsp_host_state_t;
endpackage

// ---- tcsp_if.sv ----
// Parallel control bus between host processor and tuner device
`timescale 1ns/1ps
interface tcsp_if;
  logic       cs_n;
  logic       rw;
  logic [3:0] addr;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic       int_n;
  logic       pulse_out_n;
  logic [7:0] data;

  // Resolved bus level; an undriven bus reads as pulled high
  assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);

  modport device (input cs_n, rw, addr, data,
                  output dev_data, dev_data_oe, int_n, pulse_out_n);
  modport host (output cs_n, rw, addr, host_data, host_data_oe,
                input data, int_n, pulse_out_n);
endinterface

// ---- tcsp_device.sv ----
// Tuner device end: control registers, syncs, keepalive and output pins
`timescale 1ns/1ps
module tcsp_device
  import tcsp_pkg::*;
#(
  parameter int unsigned KEEPALIVE_CYCLES = KEEPALIVE_CYC,
  parameter int unsigned SLEEP_DIVIDE     = SLEEP_DIV,
  parameter int unsigned SYNC_BITS        = SYNC_LOG2
)(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Control bus
  tcsp_if.device           ctl,
  // Sample and sync pins
  input  wire logic [11:0] sample_i,
  input  wire logic        sys_sync_n_i,
  input  wire logic        gain_sync_n_i,
  input  wire logic        accum_sync_n_i,
  input  wire logic        ck_mon_i,
  // Output pins
  input  wire logic        real_drive_en_n_i,
  input  wire logic        second_drive_en_n_i,
  output logic      [15:0] i_word_o,
  output logic             i_word_oe_o,
  output logic      [15:0] q_word_o,
  output logic             q_word_oe_o,
  output logic             word_strobe_o,
  output logic             pair_first_marker_o,
  output logic             overflow_n_o,
  output logic             sync_out_n_o,
  // Datapath side
  input  wire logic [15:0] dp_i_i,
  input  wire logic [15:0] dp_q_i,
  input  wire logic        dp_valid_i,
  input  wire logic        dp_ovf_i,
  output logic      [11:0] dp_sample_o,
  output logic             dp_gain_sync_o,
  output logic             dp_accum_sync_o,
  output logic             dp_sync_o,
  output logic             dp_reinit_o,
  output logic             dp_run_o,
  output logic             sleep_o
);
  localparam int KA_W = $clog2(KEEPALIVE_CYCLES + 1);
  localparam int SL_W = $clog2(SLEEP_DIVIDE + 1);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic [7:0]      regs [0:15];
  logic            cs_s1, cs_s2, cs_s3;
  logic            fire;
  logic            wr_fire;
  logic            rd_fire;
  logic            ready, ovf_st;
  logic [7:0]      chk_acc, chk;
  logic [15:0]     hold_i, hold_q, q_pend;
  logic            half_pend, ws_tog;
  logic            ck_q, ck_prev, clk_lost;
  logic [KA_W-1:0] ka_cnt;
  logic [SL_W-1:0] sl_cnt;
  logic            sleep, run, slow_tick;
  logic [SYNC_BITS-1:0] sync_cnt;
  logic            int_sync, ss_q, ss_prev, ext_sync, sync_ev;
  logic            word_ev, next_ws, ovf_ev;
  logic [15:0]     next_word;
  logic [7:0]      rd_val;

  // -----------------------------------------------------------------
  // Control strobe resynchroniser and access decode
  // -----------------------------------------------------------------
  // Only the second and third stages are looked at, so a metastable
  // first stage never reaches the decode
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end
    else
    begin
      cs_s1 <= ctl.cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end

  // Address, direction and data must stay steady while the strobe is low
  assign fire    = cs_s3 & ~cs_s2;
  assign wr_fire = fire & ~ctl.rw;
  assign rd_fire = fire & ctl.rw;

  // Writable registers; status stores the whole byte, but only its two control bits are used
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      for (int k = 0; k < 16; k++)
        regs[k] <= REG_RESET;
    end
    else if (wr_fire && ctl.addr < ADDR_CHECKSUM)
      regs[ctl.addr] <= ctl.data;

  // Read mux: live state for status, checksum and output words
  always_comb
  begin
    unique case (ctl.addr)
      ADDR_STATUS:   rd_val = {regs[ADDR_STATUS][7:6], 4'h0, ovf_st, ready};
      ADDR_CHECKSUM: rd_val = chk;
      ADDR_I_LO:     rd_val = hold_i[7:0];
      ADDR_I_HI:     rd_val = hold_i[15:8];
      ADDR_Q_LO:     rd_val = hold_q[7:0];
      ADDR_Q_HI:     rd_val = hold_q[15:8];
      default:       rd_val = regs[ctl.addr];
    endcase
  end

  // Drive the bus only during a read access with the strobe low
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      ctl.dev_data    <= 8'h00;
      ctl.dev_data_oe <= 1'b0;
    end
    else
    begin
      ctl.dev_data    <= rd_val;
      ctl.dev_data_oe <= ~ctl.cs_n & ctl.rw;
    end

  // One-shot pulse on any write to the one-shot address
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      ctl.pulse_out_n <= 1'b1;
    else
      ctl.pulse_out_n <= ~(wr_fire && ctl.addr == ADDR_ONE_SHOT);

  // -----------------------------------------------------------------
  // Keepalive and power down
  // -----------------------------------------------------------------
  // The watched clock is sampled; no edge for the timeout means loss
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      ck_q    <= 1'b0;
      ck_prev <= 1'b0;
      ka_cnt  <= '0;
    end
    else
    begin
      ck_q    <= ck_mon_i;
      ck_prev <= ck_q;
      if (ck_q != ck_prev)
        ka_cnt <= '0;
      else if (ka_cnt != KA_W'(KEEPALIVE_CYCLES))
        ka_cnt <= ka_cnt + 1'b1;
    end

  assign clk_lost = (ka_cnt == KA_W'(KEEPALIVE_CYCLES))
                  & ~regs[ADDR_GAIN_EXP][KEEPALIVE_OFF_BIT];
  assign sleep    = regs[ADDR_STATUS][STAT_POWER_DOWN_BIT] | clk_lost;

  // Slow tick divider; in sleep the sync counter, word path, ready and overflow only advance on this tick
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      sl_cnt <= '0;
    else if (slow_tick)
      sl_cnt <= '0;
    else
      sl_cnt <= sl_cnt + 1'b1;

  assign slow_tick = (sl_cnt == SL_W'(SLEEP_DIVIDE - 1));
  assign run       = ~sleep | slow_tick;

  // -----------------------------------------------------------------
  // Input capture and syncs
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      dp_sample_o     <= 12'h000;
      ss_q            <= 1'b1;
      ss_prev         <= 1'b1;
      dp_gain_sync_o  <= 1'b0;
      dp_accum_sync_o <= 1'b0;
    end
    else
    begin
      dp_sample_o     <= sample_i;
      ss_q            <= sys_sync_n_i;
      ss_prev         <= ss_q;
      dp_gain_sync_o  <= ~gain_sync_n_i;
      dp_accum_sync_o <= ~accum_sync_n_i;
    end

  // Internal sync counter; the test bit shortens the period
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      sync_cnt <= '0;
    else if (run)
      sync_cnt <= sync_cnt + 1'b1;

  assign int_sync = run & (regs[ADDR_SYNC_MODE][SYNC_TEST_BIT]
                  ? (&sync_cnt[TEST_LOG2-1:0]) : (&sync_cnt));
  assign ext_sync = ss_prev & ~ss_q;
  assign sync_ev  = regs[ADDR_SYNC_MODE][SYNC_INT_SEL_BIT] ? int_sync : ext_sync;

  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      sync_out_n_o <= 1'b1;
      dp_sync_o    <= 1'b0;
      dp_reinit_o  <= 1'b0;
      dp_run_o     <= 1'b1;
      sleep_o      <= 1'b0;
    end
    else
    begin
      sync_out_n_o <= regs[ADDR_SYNC_MODE][SYNC_INT_SEL_BIT] ? ~int_sync : ss_q;
      dp_sync_o    <= sync_ev;
      dp_reinit_o  <= sync_ev & regs[ADDR_SYNC_MODE][SYNC_DIAG_BIT];
      dp_run_o     <= run;
      sleep_o      <= sleep;
    end

  // -----------------------------------------------------------------
  // Output words, strobe and marker
  // -----------------------------------------------------------------
  assign word_ev   = run & (half_pend | dp_valid_i);
  assign next_word = half_pend ? q_pend : dp_i_i;
  assign next_ws   = regs[ADDR_OUT_MODE][OUT_WS_SQUARE_BIT] ? (ws_tog ^ word_ev) : word_ev;

  // In interleaved mode the quadrature half follows one run cycle later;
  // a new datapath word during that half is dropped
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      i_word_o            <= 16'h0000;
      q_word_o            <= 16'h0000;
      q_pend              <= 16'h0000;
      half_pend           <= 1'b0;
      pair_first_marker_o <= 1'b0;
      ws_tog              <= 1'b0;
      word_strobe_o       <= 1'b0;
    end
    else
    begin
      word_strobe_o <= next_ws ^ regs[ADDR_OUT_MODE][OUT_WS_POL_BIT];
      ws_tog        <= next_ws;
      if (word_ev)
      begin
        i_word_o <= next_word;
        if (regs[ADDR_OUT_MODE][OUT_INTERLEAVE_BIT])
        begin
          q_word_o            <= 16'h0000;
          pair_first_marker_o <= ~half_pend;
          half_pend           <= ~half_pend;
          q_pend              <= dp_q_i;
        end
        else
        begin
          q_word_o            <= dp_q_i;
          pair_first_marker_o <= 1'b0;
          half_pend           <= 1'b0;
        end
      end
    end

  // Enables follow the drive-enable pins one clock later
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      i_word_oe_o <= 1'b0;
      q_word_oe_o <= 1'b0;
    end
    else
    begin
      i_word_oe_o <= ~real_drive_en_n_i;
      q_word_oe_o <= ~second_drive_en_n_i;
    end

  // -----------------------------------------------------------------
  // Status, ready, overflow and checksum
  // -----------------------------------------------------------------
  assign ovf_ev = run & dp_ovf_i;

  // A new sample wins over the read that clears ready
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      ready     <= 1'b0;
      ovf_st    <= 1'b0;
      hold_i    <= 16'h0000;
      hold_q    <= 16'h0000;
      ctl.int_n <= 1'b1;
    end
    else
    begin
      if (run & dp_valid_i)
      begin
        hold_i <= dp_i_i;
        hold_q <= dp_q_i;
      end
      ready     <= (run & dp_valid_i) | (ready & ~(rd_fire && ctl.addr == ADDR_Q_HI));
      ovf_st    <= ovf_ev | (ovf_st & ~(wr_fire && ctl.addr == ADDR_STATUS));
      ctl.int_n <= ~ready;
    end

  // Hold mode keeps the pin low until status is written
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      overflow_n_o <= 1'b1;
    else
      overflow_n_o <= ~(ovf_ev | (regs[ADDR_STATUS][STAT_OVF_HOLD_BIT] & ovf_st));

  // Signature over the words loaded into i_word_o, latched and restarted on each diagnostic sync
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      chk_acc <= 8'h00;
      chk     <= 8'h00;
    end
    else if (sync_ev & regs[ADDR_SYNC_MODE][SYNC_DIAG_BIT])
    begin
      chk     <= chk_acc;
      chk_acc <= 8'h00;
    end
    else if (word_ev)
      chk_acc <= {chk_acc[6:0], chk_acc[7]} ^ next_word[15:8] ^ next_word[7:0];
endmodule

// ---- tcsp_host.sv ----
// Host end: sequences single register accesses on the parallel control bus
`timescale 1ns/1ps
module tcsp_host
  import tcsp_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Control bus
  tcsp_if.host            ctl,
  // Command side
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [3:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic      [7:0] rsp_data_o,
  output logic            sample_ready_o,
  output logic            one_shot_o
);
  tcsp_host_state_t state;
  logic [2:0]       cnt;

  // Address, direction and data are set a cycle before the strobe falls
  // and held through recovery, so the device sees them steady
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      state            <= TCSP_IDLE;
      cnt              <= 3'h0;
      ctl.cs_n         <= 1'b1;
      ctl.rw           <= 1'b1;
      ctl.addr         <= 4'h0;
      ctl.host_data    <= 8'h00;
      ctl.host_data_oe <= 1'b0;
      cmd_ready_o      <= 1'b1;
      rsp_valid_o      <= 1'b0;
      rsp_data_o       <= 8'h00;
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      unique case (state)
        TCSP_IDLE:
          if (cmd_valid_i)
          begin
            ctl.addr         <= cmd_addr_i;
            ctl.rw           <= ~cmd_write_i;
            ctl.host_data    <= cmd_wdata_i;
            ctl.host_data_oe <= cmd_write_i;
            cmd_ready_o      <= 1'b0;
            state            <= TCSP_SETUP;
          end
        TCSP_SETUP:
        begin
          ctl.cs_n <= 1'b0;
          cnt      <= 3'(HOST_STROBE_CYC - 1);
          state    <= TCSP_STROBE;
        end
        TCSP_STROBE:
          if (cnt == 3'h0)
          begin
            ctl.cs_n    <= 1'b1;
            rsp_data_o  <= ctl.data;
            rsp_valid_o <= ctl.rw;
            cnt         <= 3'(HOST_RECOVER_CYC - 1);
            state       <= TCSP_RECOVER;
          end
          else
            cnt <= cnt - 1'b1;
        TCSP_RECOVER:
          if (cnt == 3'h0)
          begin
            ctl.host_data_oe <= 1'b0;
            ctl.rw           <= 1'b1;
            cmd_ready_o      <= 1'b1;
            state            <= TCSP_IDLE;
          end
          else
            cnt <= cnt - 1'b1;
      endcase
    end

  // Device flags brought to the command side
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      sample_ready_o <= 1'b0;
      one_shot_o     <= 1'b0;
    end
    else
    begin
      sample_ready_o <= ~ctl.int_n;
      one_shot_o     <= ~ctl.pulse_out_n;
    end
endmodule

// ---- tcsp_monitor.sv ----
// Checker for the control bus between the host and device ends
`timescale 1ns/1ps
module tcsp_monitor
  import tcsp_pkg::*;
(
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       rst_i,
  // Bus signals
  input wire logic       cs_n,
  input wire logic       rw,
  input wire logic [3:0] addr,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe,
  input wire logic       pulse_out_n
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // Write strobes, split by target address
  // ---------------------------------------------------------------
  sequence s_pulse_wr;
    $fell(cs_n) && !rw && addr == ADDR_ONE_SHOT;
  endsequence
  sequence s_other_wr;
    $fell(cs_n) && !rw && addr != ADDR_ONE_SHOT;
  endsequence

  a_pulse_one_wide: assert property ($fell(pulse_out_n) |=> pulse_out_n)
    else $error("one-shot pulse wider than one cycle");
  a_pulse_after_wr: assert property (s_pulse_wr |-> ##3 $fell(pulse_out_n))
    else $error("one-shot pulse not three cycles after strobe");
  a_pulse_only_ten: assert property (s_other_wr |-> pulse_out_n [*8])
    else $error("one-shot pulse after other write");
  a_pulse_cause: assert property ($fell(pulse_out_n) |->
    $past(cs_n, 3) == 1'b0 && $past(cs_n, 4) && addr == ADDR_ONE_SHOT && !rw)
    else $error("one-shot pulse without write strobe");
  a_drive_on_read: assert property (!cs_n && rw |=> dev_data_oe)
    else $error("device not driving during read");
  a_drive_only_read: assert property (dev_data_oe |-> !$past(cs_n) && $past(rw))
    else $error("device driving outside read");
  a_bus_release: assert property (cs_n |=> !dev_data_oe)
    else $error("device kept bus after strobe");
  a_no_contention: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
endmodule

// ---- tb_top.sv ----
// Self-checking bench joining the host and device ends of the control port
`timescale 1ns/1ps
module tb_top;
  import tcsp_pkg::*;
  // Shortened sync counter keeps the run brief
  localparam int SB = 10;
  logic        clock_i, rst_i, cmd_valid_i, cmd_write_i, cmd_ready_o, rsp_valid_o;
  logic        sample_ready_o, one_shot_o, ck_run;
  logic [3:0]  cmd_addr_i;
  logic [7:0]  cmd_wdata_i, rsp_data_o, q, v;
  logic [11:0] sample_i, dp_sample_o;
  logic        sys_sync_n_i, gain_sync_n_i, accum_sync_n_i, ck_mon_i;
  logic        real_drive_en_n_i, second_drive_en_n_i, dp_valid_i, dp_ovf_i;
  logic [15:0] dp_i_i, dp_q_i, i_word_o, q_word_o;
  logic        i_word_oe_o, q_word_oe_o, word_strobe_o, pair_first_marker_o;
  logic        overflow_n_o, sync_out_n_o, dp_gain_sync_o, dp_accum_sync_o;
  logic        dp_sync_o, dp_reinit_o, dp_run_o, sleep_o;
  logic [7:0]  modes [3] = '{8'h00, 8'h02, 8'h04};
  int          err_count, checks, pulses, shots, n;

  tcsp_if bus ();
  tcsp_device #(.KEEPALIVE_CYCLES(20), .SLEEP_DIVIDE(4), .SYNC_BITS(SB)) i_tcsp_device (
    .clock_i, .rst_i, .ctl(bus), .sample_i, .sys_sync_n_i, .gain_sync_n_i,
    .accum_sync_n_i, .ck_mon_i, .real_drive_en_n_i, .second_drive_en_n_i,
    .i_word_o, .i_word_oe_o, .q_word_o, .q_word_oe_o, .word_strobe_o,
    .pair_first_marker_o, .overflow_n_o, .sync_out_n_o, .dp_i_i, .dp_q_i,
    .dp_valid_i, .dp_ovf_i, .dp_sample_o, .dp_gain_sync_o, .dp_accum_sync_o,
    .dp_sync_o, .dp_reinit_o, .dp_run_o, .sleep_o);
  tcsp_host i_tcsp_host (.clock_i, .rst_i, .ctl(bus), .cmd_valid_i, .cmd_write_i,
    .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .rsp_data_o,
    .sample_ready_o, .one_shot_o);
  tcsp_monitor i_tcsp_monitor (.clock_i, .rst_i, .cs_n(bus.cs_n), .rw(bus.rw),
    .addr(bus.addr), .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
    .pulse_out_n(bus.pulse_out_n));

  // ---------------------------------------------------------------
  // Clock, watched clock, pulse counter and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clock_i = 0;
    forever #25 clock_i = ~clock_i;
  end
  // Watched clock toggles on the falling edge so it never races the sampler
  always @(negedge clock_i)
    if (ck_run) ck_mon_i <= ~ck_mon_i;
  // Count one-shot low cycles on the pin and as seen by the host end
  always @(posedge clock_i)
  begin
    if (bus.pulse_out_n === 1'b0) pulses++;
    if (one_shot_o === 1'b1) shots++;
  end
  // Generous bound: the whole run needs about four thousand cycles
  initial
  begin
    #(30000 * 50);
    err_count++;
    summarize();
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock_i);
  endtask
  // One host command; waits for ready again, capturing read data on the way
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(negedge clock_i);
    cmd_valid_i = 1;
    cmd_write_i = w;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    cyc(2);
    cmd_valid_i = 0;
    while (cmd_ready_o !== 1'b1 && k < 30)
    begin
      if (rsp_valid_o === 1'b1)
        q = rsp_data_o;
      cyc(1);
      k++;
    end
    if (k >= 30) chk("bus timeout", 0, 1);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    q = 8'hxx;
    acc(0, a, 8'h00);
    chk("register read", {8'h00, e}, {8'h00, q});
  endtask
  // Present one complex word from the datapath
  task automatic word();
    @(negedge clock_i);
    dp_valid_i = 1;
    dp_i_i = 16'($urandom);
    dp_q_i = 16'($urandom);
    cyc(1);
    dp_valid_i = 0;
  endtask
  function automatic logic sig(int s);
    return s ? dp_reinit_o : !sync_out_n_o;
  endfunction
  task automatic per(input int s, input int e);
    n = 0;
    while (sig(s) !== 1'b1 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end while (sig(s) !== 1'b1 && n < 3000);
    chk("sync period", e, 16'(n));
    chk("sync pulse", 1, dp_sync_o);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst_i, sys_sync_n_i, gain_sync_n_i, accum_sync_n_i, second_drive_en_n_i} = 5'h1F;
    {cmd_valid_i, cmd_write_i, cmd_addr_i, cmd_wdata_i, ck_mon_i, ck_run} = 0;
    {real_drive_en_n_i, dp_valid_i, dp_ovf_i, sample_i, dp_i_i, dp_q_i} = 0;
    {err_count, checks, pulses, shots} = 0;
    second_drive_en_n_i = 0;
    void'($urandom(32'h95e08566));
    ck_run = 1;
    cyc(2);
    rst_i = 0;
    for (int a = 0; a < 10; a++) rc(a, REG_RESET);
    for (int a = 0; a < 7; a++)
      if (a != 4)
      begin
        v = 8'($urandom);
        acc(1, a, v);
        rc(a, v);
      end
    chk("no stray pulse", 0, 16'(pulses));
    for (int k = 0; k < 3; k++) acc(1, ADDR_ONE_SHOT, 8'($urandom));
    chk("one-shot cycles", 3, 16'(pulses));
    chk("host one-shot", 3, 16'(shots));
    $display("registers and one-shot done");
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clock_i);
      sample_i = 12'($urandom);
      {gain_sync_n_i, accum_sync_n_i} = 2'($urandom);
      cyc(1);
      chk("sample", {4'h0, sample_i}, {4'h0, dp_sample_o});
      chk("syncs", {!gain_sync_n_i, !accum_sync_n_i}, {dp_gain_sync_o, dp_accum_sync_o});
    end
    $display("input capture done");
    foreach (modes[m])
    begin
      acc(1, ADDR_OUT_MODE, modes[m]);
      v[0] = word_strobe_o;
      word();
      chk("i word", dp_i_i, i_word_o);
      chk("q word", dp_q_i, q_word_o);
      chk("drive", 1, {i_word_oe_o, q_word_oe_o} == 2'b11);
      chk("strobe", modes[m][1] ? !v[0] : !modes[m][2], word_strobe_o);
      cyc(1);
      if (!modes[m][1]) chk("strobe idle", modes[m][2], word_strobe_o);
    end
    acc(1, ADDR_OUT_MODE, 8'h01);
    word();
    chk("first half", {dp_i_i, 16'h0}, {i_word_o, q_word_o});
    chk("first marker", 1, pair_first_marker_o);
    cyc(1);
    chk("second half", dp_q_i, i_word_o);
    chk("second marker", 0, pair_first_marker_o);
    real_drive_en_n_i = 1;
    cyc(2);
    chk("release", 2'b01, {i_word_oe_o, q_word_oe_o});
    real_drive_en_n_i = 0;
    acc(1, ADDR_OUT_MODE, 8'h00);
    word();
    cyc(2);
    chk("ready", 2'b01, {bus.int_n, sample_ready_o});
    rc(ADDR_I_LO, dp_i_i[7:0]);
    rc(ADDR_I_HI, dp_i_i[15:8]);
    rc(ADDR_Q_LO, dp_q_i[7:0]);
    rc(ADDR_Q_HI, dp_q_i[15:8]);
    chk("ready cleared", 1, bus.int_n);
    $display("output words done");
    for (int h = 0; h < 2; h++)
    begin
      acc(1, ADDR_STATUS, h ? 8'h40 : 8'h00);
      @(negedge clock_i);
      dp_ovf_i = 1;
      cyc(1);
      dp_ovf_i = 0;
      chk("overflow low", 0, overflow_n_o);
      cyc(5);
      chk("overflow after", !h, overflow_n_o);
    end
    acc(1, ADDR_STATUS, 8'h00);
    chk("overflow cleared", 1, overflow_n_o);
    $display("overflow done");
    sys_sync_n_i = 0;
    n = 0;
    while (sync_out_n_o !== 1'b0 && n < 8)
    begin
      cyc(1);
      n++;
    end
    chk("sync delay", 1, n > 0 && n <= 3);
    sys_sync_n_i = 1;
    acc(1, ADDR_SYNC_MODE, 8'h80);
    per(0, 1 << SB);
    acc(1, ADDR_SYNC_MODE, 8'hC0);
    per(0, 256);
    acc(1, ADDR_SYNC_MODE, 8'hE0);
    per(1, 256);
    // Let two more diagnostic periods pass; no words ran, so the signature is empty
    cyc(512);
    rc(ADDR_CHECKSUM, 8'h00);
    acc(1, ADDR_SYNC_MODE, 8'h00);
    $display("sync done");
    acc(1, ADDR_STATUS, 8'h80);
    cyc(2);
    n = 0;
    for (int k = 0; k < 40; k++)
    begin
      cyc(1);
      n += dp_run_o;
    end
    chk("slow run", 16'd10, 16'(n));
    chk("sleeping", 1, sleep_o);
    acc(1, ADDR_STATUS, 8'h00);
    cyc(2);
    chk("awake", 0, sleep_o);
    acc(1, ADDR_GAIN_EXP, 8'h20);
    ck_run = 0;
    cyc(30);
    chk("watcher off", 0, sleep_o);
    acc(1, ADDR_GAIN_EXP, 8'h00);
    cyc(30);
    chk("clock loss", 1, sleep_o);
    $display("power down done");
    summarize();
  end
endmodule
